// >>> common/cbsc_pkg.sv
// Constants for the bridge system control register bank.
// Assumes a per-function configuration access port clocked by CORE_CLK.
// Contract
// RULE1: I/O write to base is index port, base plus one is data port; one shared base.
// RULE2: Legacy base bit 0 reads one always; reset value is one.
// RULE3: Two-bit field rotates serialized slots A/B, B/C, C/D, D/A for codes 0 to 3.
// RULE4: Tie bit merges both interrupts onto A; rotation still shifts it.
// RULE5: Software configures terminal three for serialized stream before setting tie bit.
// RULE6: Bits 28, 23, 7 read zero; bit 12 reads one; all read only.
// RULE7: Clock bit clear takes switch clock as input; set drives it from core clock.
// RULE8: Routing bit clear signals power write on IRQ2; set raises card status change.
// RULE9: Per-socket SMI flag sets on power write when enabled; write one clears.
// RULE10: SMI enable set raises interrupt on each socket power write; resets disabled.
// RULE11: Spare terminal bit one drives spare terminals low while card inserted; zero floats.
// RULE12: Reduced video mode floats address lines 25 to 22 of 16-bit card.
// RULE13: DMA requests forwarded only with both enables; three-bit channel, default 4.
// RULE14: Downstream read bursts need bit 15 (default set); upstream need bit 14.
// RULE15: Per-socket access flag sets on card access; reading clears it.
// RULE16: Stream busy, power-up wait and power-down wait flags are read-only status.
// RULE17: Per-socket probe busy flag is high during interrogation; resets zero.
// RULE18: Power savings stops socket state machine clock when card idle without clock.
// RULE19: Write-lock bit one makes identity registers read only; zero writable.
// RULE20: Parity bit set reports card data parity errors on system error.
// RULE21: Keep-clock bit set refuses stopping of PCI or card clock.
// RULE22: Mux bit clear routes ring-indicate and wake, ring first; set routes wake only.
// RULE23: While tie bit set, both functions' interrupt pin reads 0x01.
// RULE24: Global bits written through function 0 apply identically to both functions.
package cbsc_pkg;
  localparam logic [7:0]  CBSC_OFS_LEGACY_BASE = 8'h44;
  localparam logic [7:0]  CBSC_OFS_SYS_CTRL    = 8'h80;
  localparam logic [31:0] CBSC_RST_LEGACY_BASE = 32'h00000001;
  localparam logic [31:0] CBSC_RST_SYS_CTRL    = 32'h00449060;
  // Writable bits held per function
  localparam logic [31:0] CBSC_LOCAL_WMASK     = 32'h007f0041;
  // Writable bits shared by both functions
  localparam logic [31:0] CBSC_GLOBAL_WMASK    = 32'hef00c03a;
  localparam logic [31:0] CBSC_ONE_BITS        = 32'h00001000;
  localparam int B_ROT_LO = 30;
  localparam int B_TIE = 29;
  localparam int B_CLKSEL = 27;
  localparam int B_ROUTE = 26;
  localparam int B_SMIFLG = 25;
  localparam int B_SMIEN = 24;
  localparam int B_SPARE = 22;
  localparam int B_RZV = 20;
  localparam int B_DREQ = 19;
  localparam int B_CHAN_LO = 16;
  localparam int B_BDN = 15;
  localparam int B_BUP = 14;
  localparam int B_ACT = 13;
  localparam int B_STREAM = 11;
  localparam int B_UPW = 10;
  localparam int B_DNW = 9;
  localparam int B_PROBE = 8;
  localparam int B_SAVE = 6;
  localparam int B_LOCK = 5;
  localparam int B_PAR = 4;
  localparam int B_CDMA = 3;
  localparam int B_KEEP = 1;
  localparam int B_RING_MUX = 0;
  localparam logic [2:0] CBSC_CHAN_UNUSED = 3'h4;
  localparam logic [7:0] CBSC_PIN_INTA = 8'h01;
  localparam logic [7:0] CBSC_PIN_INTB = 8'h02;
  localparam logic [1:0] CBSC_SWCLK_DIV = 2'h3;
endpackage

// >>> core/cbsc_socket.sv
// Per-socket status flags: SMI flag and card access flag.
// Assumes event inputs are one-cycle pulses synchronous to CORE_CLK.
module cbsc_socket
  import cbsc_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // Events
  input  wire logic pwr_write,
  input  wire logic smi_enable,
  input  wire logic smi_clear,
  input  wire logic card_access,
  input  wire logic act_read,
  // State
  output logic      smi_flag_ff,
  output logic      act_flag_ff
);
  always_ff @(posedge clk) begin
    if (srst) begin
      smi_flag_ff <= 1'b0;
    end else if (pwr_write && smi_enable) begin
      smi_flag_ff <= 1'b1; // RULE9
    end else if (smi_clear) begin
      smi_flag_ff <= 1'b0; // RULE9
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      act_flag_ff <= 1'b0;
    end else if (card_access) begin
      act_flag_ff <= 1'b1; // RULE15
    end else if (act_read) begin
      act_flag_ff <= 1'b0; // RULE15
    end
  end
endmodule

// >>> core/cbsc_top.sv
// System control and legacy base registers for a two-socket card bridge.
// Assumes a single-cycle config access port per function, synchronous to CORE_CLK.
module cbsc_top
  import cbsc_pkg::*;
(
  // Clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        SRST,
  // Configuration access
  input  wire logic        CFG_WR,
  input  wire logic        CFG_RD,
  input  wire logic        CFG_FUNC,
  input  wire logic [7:0]  CFG_ADDR,
  input  wire logic [3:0]  CFG_BE,
  input  wire logic [31:0] CFG_WDATA,
  output logic [31:0]      CFG_RDATA,
  output logic             CFG_RVALID,
  // Legacy I/O decode
  input  wire logic        IO_WR,
  input  wire logic [31:0] IO_ADDR,
  output logic             LEGACY_INDEX_WR,
  output logic             LEGACY_DATA_WR,
  // Socket events
  input  wire logic [1:0]  PWR_WRITE,
  input  wire logic [1:0]  CARD_ACCESS,
  input  wire logic [1:0]  CARD_PROBE,
  input  wire logic [1:0]  CARD_INSERTED_CB,
  input  wire logic [1:0]  CARD_IDLE_NOCLK,
  input  wire logic        STREAM_BUSY,
  input  wire logic        UP_WAIT,
  input  wire logic        DOWN_WAIT,
  // Interrupts
  input  wire logic [1:0]  PCI_IRQ,
  output logic [3:0]       SERIAL_SLOT_IRQ,
  output logic [7:0]       IRQ_PIN_F0,
  output logic [7:0]       IRQ_PIN_F1,
  output logic             ISA_IRQ2,
  output logic [1:0]       STATUS_CHANGE_IRQ,
  // Switch clock
  input  wire logic        SWITCH_CLK_IN,
  output logic             SWITCH_CLK_OUT,
  output logic             SWITCH_CLK_OE,
  output logic             SWITCH_CLK,
  // Card terminals
  output logic [1:0]       SPARE_TERM_OUT,
  output logic [1:0]       SPARE_TERM_OE,
  output logic [1:0]       ADDR_HI_OE,
  // DMA
  input  wire logic [1:0]  CARD_DREQ,
  output logic [1:0]       CENTRAL_DREQ,
  output logic [5:0]       CENTRAL_DCHAN,
  // Bursts, clocks and errors
  output logic             BURST_DOWN_EN,
  output logic             BURST_UP_EN,
  output logic [1:0]       SOCKET_SM_CLK_EN,
  output logic             ID_REGS_WRITABLE,
  input  wire logic        CARD_PARITY_ERR,
  output logic             SYSERR,
  input  wire logic        CLKSTOP_REQ,
  output logic             CLKSTOP_REFUSE,
  // Ring and wake
  input  wire logic        RING_IN,
  input  wire logic        WAKE_IN,
  output logic             RING_WAKE_PIN
);
  logic [31:0] base_ff;
  logic [31:0] glob_ff;
  logic [31:0] loc_ff [2];
  logic [1:0]  smi_flag;
  logic [1:0]  act_flag;
  logic [1:0]  probe_ff;
  logic [1:0]  smi_clr;
  logic [1:0]  act_rd;
  logic [31:0] bemask;
  logic        sel_base;
  logic        sel_ctrl;
  logic [31:0] nxt_rdata;
  logic [1:0]  rot;
  logic [1:0]  irq_a;
  logic [1:0]  irq_b;
  logic [3:0]  nxt_slots;
  logic [1:0]  div_ff;
  logic        clk_gen_ff;

  assign bemask = {{8{CFG_BE[3]}}, {8{CFG_BE[2]}}, {8{CFG_BE[1]}}, {8{CFG_BE[0]}}};
  assign sel_base = (CFG_ADDR == CBSC_OFS_LEGACY_BASE);
  assign sel_ctrl = (CFG_ADDR == CBSC_OFS_SYS_CTRL);

  // Shared base register, bit 0 hardwired
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      base_ff <= CBSC_RST_LEGACY_BASE; // RULE2
    end else if (CFG_WR && sel_base) begin
      base_ff <= ((CFG_WDATA & bemask) | (base_ff & ~bemask)) | 32'h00000001; // RULE1 RULE2
    end
  end

  // Global bits: one copy, written through function 0
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      glob_ff <= CBSC_RST_SYS_CTRL & CBSC_GLOBAL_WMASK;
    end else if (CFG_WR && sel_ctrl && !CFG_FUNC) begin
      glob_ff <= ((CFG_WDATA & bemask) | (glob_ff & ~bemask)) & CBSC_GLOBAL_WMASK; // RULE24
    end
  end

  // Per-function socket bits
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      loc_ff[0] <= CBSC_RST_SYS_CTRL & CBSC_LOCAL_WMASK;
      loc_ff[1] <= CBSC_RST_SYS_CTRL & CBSC_LOCAL_WMASK;
    end else if (CFG_WR && sel_ctrl) begin
      loc_ff[CFG_FUNC] <= ((CFG_WDATA & bemask) | (loc_ff[CFG_FUNC] & ~bemask)) & CBSC_LOCAL_WMASK;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      probe_ff <= 2'h0; // RULE17
    end else begin
      probe_ff <= CARD_PROBE; // RULE17
    end
  end

  genvar s;
  generate
    for (s = 0; s < 2; s++) begin : g_sock
      assign smi_clr[s] = CFG_WR && sel_ctrl && (CFG_FUNC == 1'(s)) && CFG_BE[3] && CFG_WDATA[B_SMIFLG];
      assign act_rd[s]  = CFG_RD && sel_ctrl && (CFG_FUNC == 1'(s)) && CFG_BE[1];
      cbsc_socket u_sock (
        .clk         (CORE_CLK),
        .srst        (SRST),
        .pwr_write   (PWR_WRITE[s]),
        .smi_enable  (glob_ff[B_SMIEN]),
        .smi_clear   (smi_clr[s]),
        .card_access (CARD_ACCESS[s]),
        .act_read    (act_rd[s]),
        .smi_flag_ff (smi_flag[s]),
        .act_flag_ff (act_flag[s])
      );
    end
  endgenerate

  // Read data assembly
  always_comb begin
    nxt_rdata = 32'h00000000;
    if (sel_base) begin
      nxt_rdata = base_ff | 32'h00000001; // RULE2
    end else if (sel_ctrl) begin
      nxt_rdata = glob_ff | loc_ff[CFG_FUNC] | CBSC_ONE_BITS; // RULE6
      nxt_rdata[B_SMIFLG] = smi_flag[CFG_FUNC]; // RULE9
      nxt_rdata[B_ACT]    = act_flag[CFG_FUNC]; // RULE15
      nxt_rdata[B_STREAM] = STREAM_BUSY; // RULE16
      nxt_rdata[B_UPW]    = UP_WAIT; // RULE16
      nxt_rdata[B_DNW]    = DOWN_WAIT; // RULE16
      nxt_rdata[B_PROBE]  = probe_ff[CFG_FUNC]; // RULE17
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      CFG_RDATA  <= 32'h00000000;
      CFG_RVALID <= 1'b0;
    end else begin
      CFG_RDATA  <= CFG_RD ? nxt_rdata : 32'h00000000;
      CFG_RVALID <= CFG_RD;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      LEGACY_INDEX_WR <= 1'b0;
      LEGACY_DATA_WR  <= 1'b0;
    end else begin
      LEGACY_INDEX_WR <= IO_WR && (IO_ADDR == (base_ff & 32'hfffffffe)); // RULE1
      LEGACY_DATA_WR  <= IO_WR && (IO_ADDR == (base_ff | 32'h00000001)); // RULE1
    end
  end

  // Interrupt merge and slot rotation
  assign rot   = glob_ff[B_ROT_LO +: 2];
  assign irq_a = glob_ff[B_TIE] ? {1'b0, |PCI_IRQ} : PCI_IRQ; // RULE4

  // Code r puts A in slot r and B in slot r+1, wrapping past D
  always_comb begin
    nxt_slots = 4'h0;
    case (rot) // RULE3
      2'h0: nxt_slots = {2'b00, irq_a};
      2'h1: nxt_slots = {1'b0, irq_a, 1'b0};
      2'h2: nxt_slots = {irq_a, 2'b00};
      2'h3: nxt_slots = {irq_a[0], 2'b00, irq_a[1]};
      default: nxt_slots = {2'b00, irq_a};
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      SERIAL_SLOT_IRQ <= 4'h0;
      IRQ_PIN_F0      <= CBSC_PIN_INTA;
      IRQ_PIN_F1      <= CBSC_PIN_INTB;
    end else begin
      SERIAL_SLOT_IRQ <= nxt_slots; // RULE3
      IRQ_PIN_F0      <= CBSC_PIN_INTA;
      IRQ_PIN_F1      <= glob_ff[B_TIE] ? CBSC_PIN_INTA : CBSC_PIN_INTB; // RULE23
    end
  end
  assign irq_b = PWR_WRITE & {2{glob_ff[B_SMIEN]}};

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      ISA_IRQ2          <= 1'b0;
      STATUS_CHANGE_IRQ <= 2'h0;
    end else begin
      ISA_IRQ2          <= !glob_ff[B_ROUTE] && (|irq_b); // RULE8 RULE10
      STATUS_CHANGE_IRQ <= glob_ff[B_ROUTE] ? irq_b : 2'h0; // RULE8 RULE10
    end
  end

  // Switch clock divider
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      div_ff     <= 2'h0;
      clk_gen_ff <= 1'b0;
    end else if (div_ff == CBSC_SWCLK_DIV) begin
      div_ff     <= 2'h0;
      clk_gen_ff <= !clk_gen_ff;
    end else begin
      div_ff <= div_ff + 2'h1;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      SWITCH_CLK_OUT <= 1'b0;
      SWITCH_CLK_OE  <= 1'b0;
      SWITCH_CLK     <= 1'b0;
    end else begin
      SWITCH_CLK_OUT <= clk_gen_ff;
      SWITCH_CLK_OE  <= glob_ff[B_CLKSEL]; // RULE7
      SWITCH_CLK     <= glob_ff[B_CLKSEL] ? clk_gen_ff : SWITCH_CLK_IN; // RULE7
    end
  end

  // Spare card terminals: driven low only while enabled and a card is in
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      SPARE_TERM_OUT <= 2'h0;
      SPARE_TERM_OE  <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        SPARE_TERM_OUT[i] <= 1'b0;
        SPARE_TERM_OE[i]  <= loc_ff[i][B_SPARE] && CARD_INSERTED_CB[i]; // RULE11
      end
    end
  end

  // Upper card address lines float in reduced video mode
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      ADDR_HI_OE <= 2'h3;
    end else begin
      for (int i = 0; i < 2; i++) begin
        ADDR_HI_OE[i] <= !loc_ff[i][B_RZV]; // RULE12
      end
    end
  end

  // Centralized DMA request forwarding and channel
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      CENTRAL_DREQ  <= 2'h0;
      CENTRAL_DCHAN <= {CBSC_CHAN_UNUSED, CBSC_CHAN_UNUSED};
    end else begin
      for (int i = 0; i < 2; i++) begin
        CENTRAL_DREQ[i]         <= CARD_DREQ[i] && loc_ff[i][B_DREQ] && glob_ff[B_CDMA]; // RULE13
        CENTRAL_DCHAN[3*i +: 3] <= loc_ff[i][B_CHAN_LO +: 3]; // RULE13
      end
    end
  end

  // Socket state machine clock gating for idle cards
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      SOCKET_SM_CLK_EN <= 2'h3;
    end else begin
      for (int i = 0; i < 2; i++) begin
        SOCKET_SM_CLK_EN[i] <= !(loc_ff[i][B_SAVE] && CARD_INSERTED_CB[i] && CARD_IDLE_NOCLK[i]); // RULE18
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      BURST_DOWN_EN    <= 1'b1;
      BURST_UP_EN      <= 1'b0;
      ID_REGS_WRITABLE <= 1'b0;
      SYSERR           <= 1'b0;
      CLKSTOP_REFUSE   <= 1'b0;
      RING_WAKE_PIN    <= 1'b0;
    end else begin
      BURST_DOWN_EN    <= glob_ff[B_BDN]; // RULE14
      BURST_UP_EN      <= glob_ff[B_BUP]; // RULE14
      ID_REGS_WRITABLE <= !glob_ff[B_LOCK]; // RULE19
      SYSERR           <= CARD_PARITY_ERR && glob_ff[B_PAR]; // RULE20
      CLKSTOP_REFUSE   <= CLKSTOP_REQ && glob_ff[B_KEEP]; // RULE21
      RING_WAKE_PIN    <= loc_ff[0][B_RING_MUX] ? WAKE_IN : (RING_IN | WAKE_IN); // RULE22
    end
  end
endmodule

// >>> dv/cbsc_top_props.sv
// Checker: port-level properties of the system control bank.
// Assumes it is bound to cbsc_top and sees only that module's ports.
module cbsc_top_props
  import cbsc_pkg::*;
(
  // Clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        SRST,
  // Register port
  input  wire logic [7:0]  CFG_ADDR,
  input  wire logic [31:0] CFG_RDATA,
  input  wire logic        CFG_RVALID,
  // Decode and events
  input  wire logic        IO_WR,
  input  wire logic        LEGACY_INDEX_WR,
  input  wire logic [1:0]  PWR_WRITE,
  input  wire logic        ISA_IRQ2,
  input  wire logic [1:0]  STATUS_CHANGE_IRQ,
  input  wire logic [7:0]  IRQ_PIN_F0,
  // Levels
  input  wire logic [1:0]  CARD_DREQ,
  input  wire logic [1:0]  CENTRAL_DREQ,
  input  wire logic        CARD_PARITY_ERR,
  input  wire logic        SYSERR,
  input  wire logic        CLKSTOP_REQ,
  input  wire logic        CLKSTOP_REFUSE
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SRST);
  idx_strobe_a: assert property (LEGACY_INDEX_WR |-> $past(IO_WR))
    else $error("index strobe without io write");
  base_bit0_a: assert property (CFG_RVALID && $past(CFG_ADDR) == 8'h44 |-> CFG_RDATA[0])
    else $error("base bit 0 read low");
  rsvd_bits_a: assert property (CFG_RVALID && $past(CFG_ADDR) == 8'h80 |->
    {CFG_RDATA[28], CFG_RDATA[23], CFG_RDATA[12], CFG_RDATA[7]} == 4'h2)
    else $error("reserved control bits wrong");
  pin_f0_a: assert property (!$past(SRST) |-> IRQ_PIN_F0 == CBSC_PIN_INTA)
    else $error("function 0 pin not A");
  smi_irq_a: assert property (ISA_IRQ2 |-> $past(|PWR_WRITE) && STATUS_CHANGE_IRQ == 2'h0)
    else $error("irq2 without power write");
  csc_irq_a: assert property ((STATUS_CHANGE_IRQ & ~$past(PWR_WRITE)) == 2'h0)
    else $error("status change without power write");
  dma_fwd_a: assert property ((CENTRAL_DREQ & ~$past(CARD_DREQ)) == 2'h0)
    else $error("dma request without card request");
  syserr_src_a: assert property (SYSERR |-> $past(CARD_PARITY_ERR))
    else $error("system error without parity error");
  refuse_src_a: assert property (CLKSTOP_REFUSE |-> $past(CLKSTOP_REQ))
    else $error("refusal without stop request");
  cover property (CFG_RVALID);
  cover property (ISA_IRQ2);
  cover property (LEGACY_INDEX_WR);
endmodule

bind cbsc_top cbsc_top_props i_props (.*);

// >>> dv/cbsc_host.sv
// Host model: issues single configuration accesses.
// Assumes the bench calls access one at a time.
module cbsc_host
  import cbsc_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // Configuration requests
  output logic             cfg_wr,
  output logic             cfg_rd,
  output logic             cfg_func,
  output logic [7:0]       cfg_addr,
  output logic [3:0]       cfg_be,
  output logic [31:0]      cfg_wdata
);
  initial {cfg_wr, cfg_rd, cfg_func, cfg_addr, cfg_be, cfg_wdata} = '0;
  // Terminal three is taken as set for the serial stream before any tie write
  task automatic access(input logic w, input logic f, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cfg_wr <= w;
    cfg_rd <= !w;
    cfg_func <= f;
    cfg_addr <= a;
    cfg_be <= 4'hf;
    cfg_wdata <= d;
    @(posedge clk);
    cfg_wr <= 1'h0;
    cfg_rd <= 1'h0;
    cfg_wdata <= ~d;
  endtask
endmodule

// >>> dv/cbsc_top_tb_top.sv
// Testbench for the system control bank.
// Assumes the host model and the bound checker beside the design.
module cbsc_top_tb_top
  import cbsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CORE_CLK = 1'h0, SRST, CFG_WR, CFG_RD, CFG_FUNC, IO_WR, STREAM_BUSY, UP_WAIT, DOWN_WAIT;
  logic        SWITCH_CLK_IN, CARD_PARITY_ERR, CLKSTOP_REQ, RING_IN, WAKE_IN, CFG_RVALID;
  logic        LEGACY_INDEX_WR, LEGACY_DATA_WR, ISA_IRQ2, SWITCH_CLK_OUT, SWITCH_CLK_OE, SWITCH_CLK;
  logic        BURST_DOWN_EN, BURST_UP_EN, ID_REGS_WRITABLE, SYSERR, CLKSTOP_REFUSE, RING_WAKE_PIN;
  logic [7:0]  CFG_ADDR, IRQ_PIN_F0, IRQ_PIN_F1;
  logic [3:0]  CFG_BE, SERIAL_SLOT_IRQ;
  logic [31:0] CFG_WDATA, CFG_RDATA, IO_ADDR, v;
  logic [1:0]  PWR_WRITE, CARD_ACCESS, CARD_PROBE, CARD_INSERTED_CB, CARD_IDLE_NOCLK, PCI_IRQ, CARD_DREQ;
  logic [1:0]  STATUS_CHANGE_IRQ, SPARE_TERM_OUT, SPARE_TERM_OE, ADDR_HI_OE, CENTRAL_DREQ, SOCKET_SM_CLK_EN;
  logic [5:0]  CENTRAL_DCHAN;
  logic [31:0] exp_q[$];
  int          n_errors, checks_done, seed = 49769;

  cbsc_top i_dut (.*);
  cbsc_host i_host (.clk(CORE_CLK), .cfg_wr(CFG_WR), .cfg_rd(CFG_RD), .cfg_func(CFG_FUNC),
                    .cfg_addr(CFG_ADDR), .cfg_be(CFG_BE), .cfg_wdata(CFG_WDATA));

  always #2.5 CORE_CLK = ~CORE_CLK;

  task automatic results;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      $display("mismatch at %0t got %h exp %h", $time, g, e);
      n_errors++;
    end
  endtask
  task automatic wr(input logic f, input logic [7:0] a, input logic [31:0] d);
    i_host.access(1'h1, f, a, d);
  endtask
  task automatic rd(input logic f, input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    i_host.access(1'h0, f, a, 32'h0);
  endtask
  task automatic w3;
    repeat (3) @(posedge CORE_CLK);
    @(negedge CORE_CLK);
  endtask
  task automatic io(input logic [31:0] a, input logic [1:0] e);
    @(posedge CORE_CLK);
    IO_ADDR <= a;
    IO_WR <= 1'h1;
    @(posedge CORE_CLK);
    IO_WR <= 1'h0;
    @(negedge CORE_CLK);
    chk({LEGACY_INDEX_WR, LEGACY_DATA_WR}, e);
  endtask
  task automatic pw(input logic [1:0] s, input logic [2:0] e);
    @(posedge CORE_CLK);
    PWR_WRITE <= s;
    @(posedge CORE_CLK);
    PWR_WRITE <= 2'h0;
    @(negedge CORE_CLK);
    chk({ISA_IRQ2, STATUS_CHANGE_IRQ}, e);
  endtask

  // Read results are matched against the oldest expectation
  always @(negedge CORE_CLK) begin
    if (CFG_RVALID === 1'h1) begin
      if (exp_q.size() == 0) n_errors++;
      else chk(CFG_RDATA, exp_q.pop_front());
    end
  end

  initial begin
    repeat (20000) @(posedge CORE_CLK);
    n_errors++;
    results();
  end

  initial begin
    int i;
    SRST = 1'h1;
    {IO_WR, STREAM_BUSY, UP_WAIT, DOWN_WAIT, SWITCH_CLK_IN, CARD_PARITY_ERR, CLKSTOP_REQ, RING_IN, WAKE_IN} = '0;
    {IO_ADDR, PWR_WRITE, CARD_ACCESS, CARD_PROBE, CARD_INSERTED_CB, CARD_IDLE_NOCLK, PCI_IRQ, CARD_DREQ} = '0;
    repeat (3) @(posedge CORE_CLK);
    SRST <= 1'h0;
    rd(0, 8'h44, CBSC_RST_LEGACY_BASE);
    rd(1, 8'h80, CBSC_RST_SYS_CTRL);
    rd(0, 8'h84, 32'h0);
    for (i = 0; i < 4; i++) begin
      v = $random(seed);
      @(posedge CORE_CLK);
      {STREAM_BUSY, UP_WAIT, DOWN_WAIT, WAKE_IN} <= v[3:0];
      CARD_PROBE <= {v[4], v[0]};
      SWITCH_CLK_IN <= v[5];
      w3;
      chk({SWITCH_CLK_OE, SWITCH_CLK}, {1'b0, v[5]});
      rd(0, 8'h80, CBSC_RST_SYS_CTRL | {20'h0, v[3:0], 8'h0});
    end
    @(posedge CORE_CLK);
    {STREAM_BUSY, UP_WAIT, DOWN_WAIT, WAKE_IN, CARD_PROBE} <= '0;
    wr(1, 8'h44, 32'h300);
    rd(0, 8'h44, 32'h301);
    io(32'h300, 2'h2);
    io(32'h301, 2'h1);
    io(32'h302, 2'h0);
    for (i = 0; i < 5; i++) begin
      wr(0, 8'h80, {i[1:0], i[2], 29'h0});
      @(posedge CORE_CLK);
      PCI_IRQ <= 2'h1;
      w3;
      chk(SERIAL_SLOT_IRQ, 4'h1 << i[1:0]);
      @(posedge CORE_CLK);
      PCI_IRQ <= 2'h2;
      w3;
      chk(SERIAL_SLOT_IRQ, i[2] ? 4'h1 : 4'h1 << (i[1:0] + 2'h1));
      chk(IRQ_PIN_F1, i[2] ? 8'h01 : 8'h02);
    end
    wr(0, 8'h80, 32'h01000000);
    pw(2'h1, 3'h4);
    rd(0, 8'h80, 32'h03001000);
    wr(0, 8'h80, 32'h07000000);
    pw(2'h1, 3'h1);
    rd(0, 8'h80, 32'h07001000);
    @(posedge CORE_CLK);
    CARD_ACCESS <= 2'h2;
    @(posedge CORE_CLK);
    CARD_ACCESS <= 2'h0;
    rd(1, 8'h80, 32'h05443040);
    rd(1, 8'h80, 32'h05441040);
    wr(1, 8'h80, 32'h2);
    rd(0, 8'h80, 32'h07001000);
    @(posedge CORE_CLK);
    {CARD_INSERTED_CB, CARD_IDLE_NOCLK, CARD_DREQ} <= 6'h3f;
    {CLKSTOP_REQ, CARD_PARITY_ERR, RING_IN} <= 3'h7;
    wr(0, 8'h80, 32'h085d405b);
    w3;
    chk({BURST_DOWN_EN, BURST_UP_EN, ID_REGS_WRITABLE, SWITCH_CLK_OE, CLKSTOP_REFUSE, SYSERR, RING_WAKE_PIN},
        7'h3e);
    chk({CENTRAL_DREQ, CENTRAL_DCHAN, SOCKET_SM_CLK_EN, ADDR_HI_OE, SPARE_TERM_OE, SPARE_TERM_OUT},
        {2'h1, 6'h05, 2'h2, 2'h2, 2'h1, 2'h0});
    v[0] = SWITCH_CLK;
    repeat (int'(CBSC_SWCLK_DIV) + 1) @(posedge CORE_CLK);
    @(negedge CORE_CLK);
    chk({SWITCH_CLK, SWITCH_CLK_OUT}, {2{~v[0]}});
    pw(2'h2, 3'h0);
    wr(0, 8'h80, 32'h085d405a);
    w3;
    chk(RING_WAKE_PIN, 1'h1);
    for (i = 0; i < 20 && exp_q.size() > 0; i++) @(posedge CORE_CLK);
    if (exp_q.size() > 0) n_errors++;
    results();
  end
endmodule
